/* File: arsc_adc_control.v */
/*
  Control logic around a 10-bit successive-approximation converter: start
  handling, accumulation, result register, window compare, flags, requests
  and sleep behaviour.
  Assumes an analog core that returns one sample per sampleDone pulse while
  sampleReq is high, and event inputs from another domain (synchronised here).
*/
// How it works
// R01: on completion the result register holds the value, 10-bit full scale 1023.
// R02: selecting the temperature channel switches the temperature sensor on; here only while enable is high.
// R03: software picks reference 0x0, 32 us delays and 5 pF for temperature.
// R04: window compare supports below, above, inside and outside conditions.
// R05: a matching result sets the window flag and requests its interrupt.
// R06: window compare only with non-zero mode; thresholds from two registers.
// R07: accumulated conversions compare once, after the last sample.
// R08: with event start enabled, an incoming event starts a conversion.
// R09: two vectors, result ready at 0x00 and window compare at 0x02.
// R10: flags set regardless of enable; request while flag and enable both high.
// R11: by default the converter stops in standby sleep.
// R12: with run in standby set, conversions finish and interrupts still occur.
// R13: in standby, clock requested only while a conversion is needed.
// R14: event rising edge sets the start bit; completion sets flag, clears start; here start stays set when freeRun is high.
// R15: software sets a non-zero initial delay before standby conversions.
// R16: power-down freezes a conversion; it resumes after wake-up.
// R17: a conversion broken by power-down still sets the flag; result invalid.
// R18: result-ready clears on result read or on write of one to the flag.
// R19: window compare uses the final stored result value.
`timescale 1ns/100ps
`include "arsc_defs.vh"

module arsc_adc_control #(
  parameter RES_W = `ARSC_RES_W
) (
  // clock and reset
  input  wire             core_clk,
  input  wire             rst,
  input  wire             clkEn,
  // configuration
  input  wire             enable,
  input  wire             freeRun,
  input  wire             resolution8,
  input  wire [2:0]       sampleNumber,
  input  wire [2:0]       window_compare_mode_select,
  input  wire [RES_W-1:0] window_low_threshold,
  input  wire [RES_W-1:0] window_high_threshold,
  input  wire [4:0]       input_channel_select,
  input  wire             event_start_enable,
  input  wire             run_in_standby,
  input  wire [1:0]       interrupt_enable_register,
  // software commands
  input  wire             startWrite,
  input  wire             resultRead,
  input  wire [1:0]       flagClearWrite,
  // sleep state
  input  wire             standbySleep,
  input  wire             powerDownSleep,
  // event router input (asynchronous)
  input  wire             event_router,
  // analog core
  input  wire             sampleDone,
  input  wire [9:0]       sampleData,
  output reg              sampleReq,
  output reg              tempSensorOn,
  output reg              clockRequest,
  // results and status
  output reg              start_conversion_bit,
  output reg  [RES_W-1:0] conversion_result,
  output reg              resultValid,
  output reg  [1:0]       interrupt_flag_register,
  output reg              resultReadyIrq,
  output reg              windowIrq,
  output reg  [7:0]       vectorOffset
);

  // ==========================================================
  // event synchroniser and edge detect
  reg             evMeta;
  reg             evSync;
  reg             evLast;
  reg [RES_W-1:0] acc;
  reg [`ARSC_CNT_W-1:0] sampleCount;
  reg             haltedMid;

  wire evRise  = evSync & ~evLast;
  // see R11, see R16: standby without run bit or power-down freezes progress
  wire frozen  = powerDownSleep | (standbySleep & ~run_in_standby);
  wire running = enable & ~frozen;

  function [`ARSC_CNT_W-1:0] samplesFor;
    input [2:0] n;
    begin
      samplesFor = (n == 3'h7) ? 7'h01 : (7'h01 << n);
    end
  endfunction

  // see R04, see R06
  function winMatch;
    input [2:0]       mode;
    input [RES_W-1:0] v;
    input [RES_W-1:0] lo;
    input [RES_W-1:0] hi;
    begin
      case (mode)
        `ARSC_WIN_BELOW:   winMatch = (v < lo);
        `ARSC_WIN_ABOVE:   winMatch = (v > hi);
        `ARSC_WIN_INSIDE:  winMatch = (v > lo) && (v < hi);
        `ARSC_WIN_OUTSIDE: winMatch = (v < lo) || (v > hi);
        default:           winMatch = 1'b0;
      endcase
    end
  endfunction

  // ==========================================================
  // sample scaling: 10-bit full scale 1023, or 8-bit truncation
  wire [RES_W-1:0] scaled = resolution8 ? {8'h00, sampleData[9:2]}
                                        : {6'h00, sampleData & `ARSC_FULL_SCALE}; // see R01
  wire [`ARSC_CNT_W-1:0] target = samplesFor(sampleNumber);
  wire [RES_W-1:0] accNext = acc + scaled;
  wire lastSample  = sampleDone & sampleReq & (sampleCount + 7'h01 == target);
  wire startTrig   = startWrite | (event_start_enable & evRise); // see R08

  // ==========================================================
  // event pin: two flip-flops before any use, then an edge detector
  // evLast resets to the idle low level, so leaving reset makes no false edge
  always @(posedge core_clk) begin
    if (rst) begin
      evMeta <= 1'b0;
      evSync <= 1'b0;
      evLast <= 1'b0;
    end else if (clkEn) begin
      evMeta <= event_router;
      evSync <= evMeta;
      evLast <= evSync;
    end
  end

  // ==========================================================
  // temperature sensor supply
  always @(posedge core_clk) begin
    if (rst) begin
      tempSensorOn <= 1'b0;
    end else if (clkEn) begin
      // follows the channel select while enable is high so the sensor settles before sampling
      tempSensorOn <= enable & (input_channel_select == `ARSC_TEMP_CHANNEL); // see R02
    end
  end

  // ==========================================================
  // conversion sequencing
  always @(posedge core_clk) begin
    if (rst) begin
      acc <= `ARSC_RES_RST;
      sampleCount <= {`ARSC_CNT_W{1'b0}};
      haltedMid <= 1'b0;
      sampleReq <= 1'b0;
      clockRequest <= 1'b0;
      start_conversion_bit <= 1'b0;
      conversion_result <= `ARSC_RES_RST;
      resultValid <= 1'b0;
      interrupt_flag_register <= 2'b00;
    end else if (clkEn) begin
      // see R16: remember a conversion caught by power-down
      if (powerDownSleep & start_conversion_bit)
        haltedMid <= 1'b1;
      // flag clears first; a set below wins in the same cycle
      if (resultRead | flagClearWrite[0])
        interrupt_flag_register[0] <= 1'b0; // see R18
      if (flagClearWrite[1])
        interrupt_flag_register[1] <= 1'b0;
      // a start while busy is dropped; free-running restarts at completion
      if (enable & startTrig & ~start_conversion_bit & ~powerDownSleep)
        start_conversion_bit <= 1'b1; // see R14
      sampleReq <= running & start_conversion_bit & ~lastSample;
      // see R13: clock held only while a conversion is pending
      clockRequest <= enable & (start_conversion_bit | startTrig);
      if (running & sampleDone & sampleReq) begin
        if (lastSample) begin
          // see R07, see R01: publish once after the final sample
          conversion_result <= accNext;
          acc <= `ARSC_RES_RST;
          sampleCount <= {`ARSC_CNT_W{1'b0}};
          resultValid <= ~haltedMid; // see R17
          haltedMid <= 1'b0;
          interrupt_flag_register[0] <= 1'b1; // see R10, see R12
          // see R05, see R19: compare exactly the stored value
          if (winMatch(window_compare_mode_select, accNext,
                       window_low_threshold, window_high_threshold))
            interrupt_flag_register[1] <= 1'b1;
          start_conversion_bit <= freeRun; // see R14
        end else begin
          acc <= accNext;
          sampleCount <= sampleCount + 7'h01;
        end
      end
      if (~enable) begin
        start_conversion_bit <= 1'b0;
        acc <= `ARSC_RES_RST;
        sampleCount <= {`ARSC_CNT_W{1'b0}};
      end
    end
  end

  // ==========================================================
  // interrupt requests
  // see R10: requests follow flag and enable; vector picks ready first
  always @(posedge core_clk) begin
    if (rst) begin
      resultReadyIrq <= 1'b0;
      windowIrq      <= 1'b0;
      vectorOffset   <= `ARSC_VEC_RESULT_READY_FLAG;
    end else if (clkEn) begin
      resultReadyIrq <= interrupt_flag_register[0] & interrupt_enable_register[0];
      windowIrq      <= interrupt_flag_register[1] & interrupt_enable_register[1];
      vectorOffset   <= (interrupt_flag_register[0] & interrupt_enable_register[0])
                        ? `ARSC_VEC_RESULT_READY_FLAG : `ARSC_VEC_WINDOW; // see R09
    end
  end

endmodule

/* File: arsc_defs.vh */
/*
  Shared constants for the converter result, window and sleep control block.
  Assumes inclusion by bare name from the design file; holds only definitions.
*/
`ifndef ARSC_DEFS_VH
`define ARSC_DEFS_VH

// ==========================================================
// window compare modes
`define ARSC_WIN_OFF      3'h0
`define ARSC_WIN_BELOW    3'h1
`define ARSC_WIN_ABOVE    3'h2
`define ARSC_WIN_INSIDE   3'h3
`define ARSC_WIN_OUTSIDE  3'h4

// ==========================================================
// interrupt vector offsets
`define ARSC_VEC_RESULT_READY_FLAG   8'h00
`define ARSC_VEC_WINDOW   8'h02

// ==========================================================
// reset values and field widths
`define ARSC_RES_W        16
`define ARSC_RES_RST      16'h0000
`define ARSC_CNT_W        7
`define ARSC_FULL_SCALE   10'h3FF
`define ARSC_TEMP_CHANNEL 5'h1E

`endif

/* File: arsc_adc_control_chk.sv */
/* Checker for the converter control block: timing of flags, results and requests.
   Assumes it is bound to arsc_adc_control and sees only its ports. */
`timescale 1ns/100ps
module arsc_adc_control_chk #(parameter RES_W = 16) (
  // clock, reset and inputs
  input wire             core_clk, rst, clkEn, freeRun, resolution8, resultRead,
  input wire             enable,
  input wire             standbySleep, powerDownSleep, run_in_standby, sampleDone,
  input wire [2:0]       sampleNumber, window_compare_mode_select,
  input wire [4:0]       input_channel_select,
  input wire [1:0]       interrupt_enable_register,
  input wire [9:0]       sampleData,
  // outputs
  input wire             sampleReq, tempSensorOn, start_conversion_bit, resultReadyIrq, windowIrq,
  input wire [RES_W-1:0] conversion_result,
  input wire [1:0]       interrupt_flag_register
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // ==========================================================
  // single sample that completes a conversion
  wire lastOne = clkEn && sampleReq && sampleDone && sampleNumber == 3'h0 && !powerDownSleep &&
                 enable && (run_in_standby || !standbySleep);
  ready_irq_a:
    assert property ($past(clkEn && !rst) |-> resultReadyIrq ==
      $past(interrupt_flag_register[0] & interrupt_enable_register[0])) else $error("ready req");
  win_irq_a:
    assert property ($past(clkEn && !rst) |-> windowIrq ==
      $past(interrupt_flag_register[1] & interrupt_enable_register[1])) else $error("window req");
  result_a:
    assert property (lastOne && !resolution8 |=> conversion_result == $past({6'h00, sampleData}))
      else $error("result value");
  done_a:
    assert property (lastOne && !freeRun |=> interrupt_flag_register[0] && !start_conversion_bit)
      else $error("completion");
  clear_a:
    assert property (clkEn && resultRead && !sampleDone |=> !interrupt_flag_register[0])
      else $error("read clear");
  win_off_a:
    assert property (clkEn && window_compare_mode_select == 3'h0 && !interrupt_flag_register[1]
      |=> !interrupt_flag_register[1]) else $error("window off");
  temp_on_a:
    assert property ($past(clkEn && !rst) |-> tempSensorOn ==
      $past(enable && input_channel_select == 5'h1E)) else $error("temp sensor");
  pd_hold_a:
    assert property (powerDownSleep |=> $stable(conversion_result) &&
      !$rose(interrupt_flag_register[0])) else $error("power-down");
endmodule
bind arsc_adc_control arsc_adc_control_chk #(.RES_W(RES_W)) chk (.core_clk, .rst, .clkEn,
  .freeRun, .resolution8, .resultRead, .standbySleep, .powerDownSleep, .run_in_standby, .enable,
  .sampleDone, .sampleNumber, .window_compare_mode_select, .input_channel_select,
  .interrupt_enable_register, .sampleData, .sampleReq, .tempSensorOn, .start_conversion_bit,
  .resultReadyIrq, .windowIrq, .conversion_result, .interrupt_flag_register);

/* File: arsc_analog_model.sv */
/* Analog core model: one sample every DLY+1 cycles while requested.
   Assumes the testbench sets the input level. */
`timescale 1ns/100ps
module arsc_analog_model #(parameter DLY = 3) (
  // ==========================================================
  // core side
  input wire       core_clk,
  input wire       sampleReq,
  input wire [9:0] level,
  output reg       sampleDone,
  output reg [9:0] sampleData
);
  reg [3:0] cnt;
  initial begin
    sampleDone = 1'h0;
    sampleData = 10'h000;
    cnt = 4'h0;
  end
  always @(posedge core_clk) begin
    sampleDone <= 1'h0;
    // data is only valid with the done pulse, so it toggles otherwise
    sampleData <= ~sampleData;
    if (!sampleReq) cnt <= 4'h0;
    else if (cnt == DLY) begin
      cnt <= 4'h0;
      sampleDone <= 1'h1;
      sampleData <= level;
    end else cnt <= cnt + 4'h1;
  end
endmodule

/* File: arsc_adc_control_tb.sv */
/* Self-checking testbench for arsc_adc_control.
   Assumes the analog model and the checker are compiled alongside. */
`timescale 1ns/100ps
module arsc_adc_control_tb;
  // ==========================================================
  // signals
  reg core_clk = 0, rst = 1, clkEn = 1, enable = 1, freeRun = 0, resolution8 = 0, e;
  reg [2:0] sampleNumber = 0, window_compare_mode_select = 0;
  reg [15:0] window_low_threshold = 16'h0064, window_high_threshold = 16'h00C8, v;
  reg [4:0] input_channel_select = 0;
  reg event_start_enable = 0, run_in_standby = 0, startWrite = 0, resultRead = 0;
  reg standbySleep = 0, powerDownSleep = 0, event_router = 0;
  reg [1:0] interrupt_enable_register = 2'h3, flagClearWrite = 0;
  reg [9:0] level = 0;
  wire sampleDone, sampleReq, tempSensorOn, clockRequest, start_conversion_bit, resultValid;
  wire resultReadyIrq, windowIrq;
  wire [7:0] vectorOffset;
  wire [9:0] sampleData;
  wire [15:0] conversion_result;
  wire [1:0] interrupt_flag_register;
  integer bad_count = 0, check_count = 0, cycles = 0, m, k;
  arsc_adc_control dut (.core_clk, .rst, .clkEn, .enable, .freeRun, .resolution8, .sampleNumber,
    .window_compare_mode_select, .window_low_threshold, .window_high_threshold,
    .input_channel_select, .event_start_enable, .run_in_standby, .interrupt_enable_register,
    .startWrite, .resultRead, .flagClearWrite, .standbySleep, .powerDownSleep, .event_router,
    .sampleDone, .sampleData, .sampleReq, .tempSensorOn, .clockRequest, .start_conversion_bit,
    .conversion_result, .resultValid, .interrupt_flag_register, .resultReadyIrq, .windowIrq,
    .vectorOffset);
  arsc_analog_model ana (.core_clk, .sampleReq, .level, .sampleDone, .sampleData);
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      bad_count = bad_count + 1;
      complete_run;
    end
  end
  task complete_run; begin
    if (bad_count == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  end endtask
  task check(input [15:0] got, input [15:0] exp); begin
    check_count = check_count + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  end endtask
  task tick(input integer n); begin repeat (n) @(posedge core_clk); #1; end endtask
  // flags are cleared on the same edge that takes the start
  task go; begin flagClearWrite = 2'h3; startWrite = 1; tick(1); flagClearWrite = 0; startWrite = 0; end endtask
  task waitf; integer i; begin
    for (i = 0; i < 300 && interrupt_flag_register[0] !== 1'h1; i = i + 1) tick(1);
  end endtask
  task conv(input [9:0] lv); begin level = lv; go; waitf; end endtask
  // ==========================================================
  // scenarios
  initial begin
    tick(20); rst = 0;
    conv(10'h3FF);
    check(conversion_result, 16'h03FF);
    check(start_conversion_bit, 1'h0);
    check(resultValid, 1'h1);
    tick(1); check(resultReadyIrq, 1'h1);
    check(vectorOffset, 16'h0000);
    resultRead = 1; tick(1); resultRead = 0; check(interrupt_flag_register[0], 1'h0);
    conv(10'h001); flagClearWrite = 2'h1; tick(1); flagClearWrite = 0;
    check(interrupt_flag_register[0], 1'h0);
    for (m = 0; m < 5; m = m + 1) for (k = 0; k < 5; k = k + 1) begin
      window_compare_mode_select = m; v = 16'h0032 * (k + 1); conv(v[9:0]);
      e = (m == 1 && v < window_low_threshold) || (m == 2 && v > window_high_threshold) ||
        (m == 3 && v > window_low_threshold && v < window_high_threshold) ||
        (m == 4 && (v < window_low_threshold || v > window_high_threshold));
      check(interrupt_flag_register[1], e);
      tick(1); check(windowIrq, e);
    end
    resultRead = 1; tick(1); resultRead = 0; tick(1);
    check(vectorOffset, 16'h0002);
    interrupt_enable_register = 0; conv(10'h3FF); check(interrupt_flag_register[1], 1'h1);
    tick(1); check(windowIrq, 1'h0);
    window_compare_mode_select = 2; window_high_threshold = 16'h001E; sampleNumber = 2;
    conv(10'h00A); check(conversion_result, 16'h0028);
    check(interrupt_flag_register[1], 1'h1);
    sampleNumber = 0; resolution8 = 1; window_high_threshold = 16'h0100; conv(10'h3FF);
    check(conversion_result, 16'h00FF);
    check(interrupt_flag_register[1], 1'h0);
    input_channel_select = 5'h1E; tick(2); check(tempSensorOn, 1'h1);
    event_router = 1; tick(10); check(start_conversion_bit, 1'h0);
    event_router = 0; event_start_enable = 1; flagClearWrite = 2'h3; tick(5); flagClearWrite = 0;
    event_router = 1; waitf; event_router = 0;
    check(interrupt_flag_register[0], 1'h1);
    check(start_conversion_bit, 1'h0);
    level = 10'h155; go; check(clockRequest, 1'h1);
    tick(2); powerDownSleep = 1; tick(20);
    check(interrupt_flag_register[0], 1'h0);
    powerDownSleep = 0; waitf; check(resultValid, 1'h0);
    go; standbySleep = 1; tick(20); check(interrupt_flag_register[0], 1'h0);
    run_in_standby = 1; waitf; check(interrupt_flag_register[0], 1'h1);
    tick(2); check(clockRequest, 1'h0);
    complete_run;
  end
endmodule
